// file: scs_pkg.sv
// Package of constants for the stepper command sequencer
// Behaviour
// - Fetch commands from a fixed start address, one after another, ascending.
// - Each command is one 16-bit word; opcode sits in bits 15..12.
// - Opcode F steps clockwise, B steps counter-clockwise, count steps each.
// - Opcode D waits as long as stepping would, coils held still.
// - Opcode E ends the program and returns control to the host.
// - Continue opcode restarts fetching at the first word of the list.
// - Speed selector in bits 11..8; 0 slowest, F fastest.
// - Step count in bits 7..0, zero through 255.
// - Motor driven through exactly four coil lines, two per coil.
// - Motion only by walking a repeating coil pattern, one position per step.
// - Each step reverses current in one stator set only.
// - Finish each command's behaviour before fetching the next word.
// - Full-step: both coils energised, alternate coil reversed, four positions.
// - Counter-clockwise walks the same pattern in reverse order.
package scs_pkg;
	localparam logic [23:0] SCS_LIST_BASE = 24'h000A00;
	localparam int SCS_OP_MSB = 15;
	localparam int SCS_OP_LSB = 12;
	localparam int SCS_SPD_MSB = 11;
	localparam int SCS_SPD_LSB = 8;
	localparam int SCS_CNT_MSB = 7;
	localparam int SCS_CNT_LSB = 0;
	localparam logic [3:0] SCS_OP_CW = 4'hF;
	localparam logic [3:0] SCS_OP_CCW = 4'hB;
	localparam logic [3:0] SCS_OP_DELAY = 4'hD;
	localparam logic [3:0] SCS_OP_END = 4'hE;
	localparam logic [3:0] SCS_OP_CONT = 4'hC;
	localparam int SCS_CLK_HZ = 25000000;
	localparam int SCS_BASE_US = 1000;
	localparam int SCS_BASE_CYC = SCS_CLK_HZ / 1000000 * SCS_BASE_US;
	localparam logic [1:0] SCS_PHASE_RST = 2'h0;
	localparam logic [3:0] SCS_COIL_RST = 4'h0;
endpackage

// file: scs_step_timer.sv
// Step interval timer: one-cycle tick every step period chosen by speed
`timescale 1ns/10ps
`default_nettype none
module scs_step_timer
	import scs_pkg::*;
#(
	parameter int BASE_CYC = SCS_BASE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [3:0] i_speed,
	// Tick
	output logic o_tick
);
	logic [31:0] cnt_q;
	logic [31:0] limit;

	// Interval is base times (17 - speed): speed 0 is 17 units, F is 2 units
	always_comb begin
		limit = 32'(BASE_CYC) * (32'd17 - {28'h0, i_speed});
	end

	always_ff @(posedge i_clk) begin
		if (i_rst || !i_run) begin
			cnt_q <= 32'h0;
		end else if (cnt_q >= limit - 32'd1) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'd1;
		end
	end

	assign o_tick = i_run && (cnt_q >= limit - 32'd1);
endmodule
`default_nettype wire

// file: scs_sequencer.sv
// Stepper command sequencer: fetches command words and drives four coil lines
`timescale 1ns/10ps
`default_nettype none
module scs_sequencer
	import scs_pkg::*;
#(
	parameter int BASE_CYC = SCS_BASE_CYC,
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Host control
	input wire logic i_start,
	output logic o_busy,
	output logic o_done,
	// Command memory read port
	output logic o_rd_req,
	output logic [ADDR_W-1:0] o_rd_addr,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rd_data,
	// Coil drive lines
	output logic [3:0] o_coil
);
	typedef enum logic [3:0] {
		SCS_IDLE = 4'b0001,
		SCS_FETCH = 4'b0010,
		SCS_WAIT = 4'b0100,
		SCS_RUN = 4'b1000
	} scs_state_e;

	scs_state_e state_q;
	logic [ADDR_W-1:0] addr_q;
	logic [3:0] op_q;
	logic [3:0] speed_q;
	logic [7:0] left_q;
	logic [1:0] phase_q;
	logic [3:0] coil_q;
	logic done_q;
	logic tick;
	logic [3:0] new_op;
	logic [7:0] new_cnt;

	// Full-step two-phase-on table; neighbours differ in one coil pair only
	function automatic logic [3:0] coil_pattern(input logic [1:0] ph);
		unique case (ph)
			2'd0: coil_pattern = 4'b1010;
			2'd1: coil_pattern = 4'b0110;
			2'd2: coil_pattern = 4'b0101;
			2'd3: coil_pattern = 4'b1001;
		endcase
	endfunction

	assign new_op = i_rd_data[SCS_OP_MSB:SCS_OP_LSB];
	assign new_cnt = i_rd_data[SCS_CNT_MSB:SCS_CNT_LSB];

	scs_step_timer #(
		.BASE_CYC(BASE_CYC)
	) u_timer (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(state_q == SCS_RUN),
		.i_speed(speed_q),
		.o_tick(tick)
	);

	// Command flow
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= SCS_IDLE;
			addr_q <= '0;
			op_q <= 4'h0;
			speed_q <= 4'h0;
			left_q <= 8'h0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				SCS_IDLE: begin
					if (i_start) begin
						addr_q <= SCS_LIST_BASE[ADDR_W-1:0];
						state_q <= SCS_FETCH;
					end
				end
				SCS_FETCH: begin
					state_q <= SCS_WAIT;
				end
				SCS_WAIT: begin
					if (i_rd_valid) begin
						op_q <= new_op;
						speed_q <= i_rd_data[SCS_SPD_MSB:SCS_SPD_LSB];
						left_q <= new_cnt;
						if (new_op == SCS_OP_CONT) begin
							addr_q <= SCS_LIST_BASE[ADDR_W-1:0];
							state_q <= SCS_FETCH;
						end else if (new_op == SCS_OP_CW || new_op == SCS_OP_CCW ||
							new_op == SCS_OP_DELAY) begin
							addr_q <= addr_q + ADDR_W'(2);
							state_q <= (new_cnt == 8'h0) ? SCS_FETCH : SCS_RUN;
						end else begin
							state_q <= SCS_IDLE;
							done_q <= 1'b1;
						end
					end
				end
				SCS_RUN: begin
					if (tick) begin
						left_q <= left_q - 8'h1;
						if (left_q == 8'h1) begin
							state_q <= SCS_FETCH;
						end
					end
				end
				default: state_q <= SCS_IDLE;
			endcase
		end
	end

	// Coil phase; delay commands let time pass without moving
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase_q <= SCS_PHASE_RST;
		end else if (state_q == SCS_RUN && tick) begin
			if (op_q == SCS_OP_CW) begin
				phase_q <= phase_q + 2'd1;
			end else if (op_q == SCS_OP_CCW) begin
				phase_q <= phase_q - 2'd1;
			end
		end
	end

	// Coils stay off until the first program starts, then hold position
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			coil_q <= SCS_COIL_RST;
		end else if (state_q != SCS_IDLE) begin
			coil_q <= coil_pattern(phase_q);
		end
	end

	assign o_coil = coil_q;
	assign o_busy = (state_q != SCS_IDLE);
	assign o_done = done_q;
	assign o_rd_req = (state_q == SCS_FETCH);
	assign o_rd_addr = addr_q;
endmodule
`default_nettype wire

// file: scs_monitor.sv
// Port assertions for the stepper command sequencer
`timescale 1ns/10ps
`default_nettype none
module scs_monitor
	import scs_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Host and memory
	input wire logic i_start,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_rd_req,
	input wire logic [ADDR_W-1:0] o_rd_addr,
	input wire logic i_rd_valid,
	input wire logic [15:0] i_rd_data,
	// Coils
	input wire logic [3:0] o_coil
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_req_pulse: assert property (o_rd_req |=> !o_rd_req) else $error("long request");
	a_start_fetch: assert property (i_start && !o_busy |=> o_rd_req) else $error("no fetch");
	a_first_addr: assert property ($rose(o_busy) |-> o_rd_addr == ADDR_W'(SCS_LIST_BASE)) else $error("base");
	a_addr_next: assert property (o_busy && $changed(o_rd_addr) |->
		o_rd_addr == $past(o_rd_addr) + 2 || o_rd_addr == ADDR_W'(SCS_LIST_BASE)) else $error("order");
	a_done_end: assert property (o_done |=> !o_busy && !o_done) else $error("end");
	a_done_cause: assert property (o_done |-> $past(i_rd_valid)) else $error("done cause");
	a_idle_hold: assert property (!o_busy ##1 !o_busy |-> $stable(o_coil)) else $error("idle move");
	a_two_on: assert property (o_coil != 4'h0 |-> $countones(o_coil) == 2) else $error("phases");
	a_one_set: assert property ($changed(o_coil) && $past(o_coil) != 4'h0 |->
		(o_coil ^ $past(o_coil)) inside {4'hC, 4'h3}) else $error("two sets");
	cover property (o_done);
	cover property ($rose(o_busy));
	cover property (o_rd_req && o_rd_addr == ADDR_W'(SCS_LIST_BASE) && $past(o_busy));
endmodule
`default_nettype wire

// file: scs_motor.sv
// Motor model: tracks rotor position from coil line changes
`timescale 1ns/10ps
`default_nettype none
module scs_motor (
	// Clock
	input wire logic i_clk,
	// Coil lines from the sequencer
	input wire logic [3:0] i_coil,
	// Rotor position in steps, clockwise positive
	output int o_pos
);
	logic [3:0] prev_q = 4'h0;
	int pos_q = 0;
	// Case equality keeps unknown coil levels from posing as a valid position
	function automatic int ix(input logic [3:0] c);
		return c === 4'hA ? 0 : c === 4'h6 ? 1 : c === 4'h5 ? 2 : c === 4'h9 ? 3 : -1;
	endfunction
	assign o_pos = pos_q;
	// Unknown or idle patterns do not count as motion
	always @(posedge i_clk) begin
		if (ix(prev_q) >= 0 && ix(i_coil) >= 0 && i_coil != prev_q)
			pos_q <= pos_q + ((ix(i_coil) - ix(prev_q) + 4) % 4 == 1 ? 1 : -1);
		prev_q <= i_coil;
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the stepper command sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic i_clk = 0, i_rst = 1, i_start = 0, i_rd_valid = 0, d1 = 0;
	logic [15:0] i_rd_data = 16'h0;
	logic [15:0] mem [8];
	logic o_busy, o_done, o_rd_req;
	logic [23:0] o_rd_addr;
	logic [3:0] o_coil;
	int pos, c, p0, num_errors = 0, tests_run = 0;
	scs_sequencer #(.BASE_CYC(4)) uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_start(i_start),
		.o_busy(o_busy),
		.o_done(o_done),
		.o_rd_req(o_rd_req),
		.o_rd_addr(o_rd_addr),
		.i_rd_valid(i_rd_valid),
		.i_rd_data(i_rd_data),
		.o_coil(o_coil)
	);
	scs_motor u_mot (.i_clk(i_clk), .i_coil(o_coil), .o_pos(pos));
	initial forever #20 i_clk = ~i_clk;
	// Memory answers a cycle late; idle data toggles so stale words never match
	always @(posedge i_clk) begin
		#1;
		i_rd_valid = d1;
		i_rd_data = d1 ? mem[o_rd_addr[3:1]] : ~i_rd_data;
		d1 = o_rd_req;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: got %0h want %0h", $time, s, e);
		end
	endtask
	task go(input logic [15:0] a, input logic [15:0] b, input logic [15:0] x, input bit w);
		mem[0] = a;
		mem[1] = b;
		mem[2] = x;
		p0 = pos;
		c = 0;
		@(posedge i_clk) #1 i_start = 1;
		@(posedge i_clk) #1 i_start = 0;
		while (w && o_done !== 1'b1 && c < 3000) begin
			@(posedge i_clk) #1 c++;
		end
		if (w) begin
			chk(c < 3000, 1);
		end
	endtask
	task test_done;
		$display("errors %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		test_done;
	end
	// Cycle counts: two per fetched word plus steps times 4*(17-speed)
	task test_direction;
		go(16'hFF03, 16'hBF01, 16'hE000, 1);
		chk(pos - p0, 2);
		chk(o_coil, 4'h5);
		chk(o_rd_addr, 24'h000A04);
		$display("direction test over");
	endtask
	task test_delay;
		go(16'hDF04, 16'hFF00, 16'hE000, 1);
		chk(pos - p0, 0);
		chk(c >= 32, 1);
		chk(c, 38);
		$display("delay test over");
	endtask
	task test_speed;
		go(16'hF001, 16'hE000, 16'hE000, 1);
		chk(c >= 68, 1);
		chk(c, 72);
		chk(pos - p0, 1);
		$display("speed test over");
	endtask
	task test_bad_opcode;
		go(16'h1000, 16'hFF01, 16'hE000, 1);
		chk(pos - p0, 0);
		$display("bad opcode test over");
	endtask
	task test_restart;
		go(16'hFF01, 16'hC000, 16'hE000, 0);
		repeat (300) @(posedge i_clk);
		#1 chk(o_busy, 1);
		chk(pos - p0 > 4, 1);
		i_rst = 1;
		repeat (2) @(posedge i_clk);
		#1 i_rst = 0;
		chk(o_busy, 0);
		chk(o_coil, 4'h0);
		chk(o_rd_addr, 24'h000000);
		$display("restart test over");
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		#1 i_rst = 0;
		chk(o_coil, 4'h0);
		test_direction;
		test_delay;
		test_speed;
		test_bad_opcode;
		test_restart;
		test_done;
	end
endmodule
bind scs_sequencer scs_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_start(i_start),
	.o_busy(o_busy),
	.o_done(o_done),
	.o_rd_req(o_rd_req),
	.o_rd_addr(o_rd_addr),
	.i_rd_valid(i_rd_valid),
	.i_rd_data(i_rd_data),
	.o_coil(o_coil)
);
`default_nettype wire
